// ### include/mil_defines.svh
// constants of the interrupt option and pin latch logic
// assumes inclusion by bare name from the interrupt controller rtl, the only file that includes it
`ifndef MIL_DEFINES_SVH
`define MIL_DEFINES_SVH
// ===========================================================
// register addresses
`define MIL_ADDR_OPTION 8'hC8
`define MIL_ADDR_LATCH 8'hED
// ===========================================================
// option register fields
`define MIL_OPT_VEC1_LEVEL 6
`define MIL_OPT_VEC2_EDGE 5
`define MIL_OPT_GLOBAL_EN 4
// ===========================================================
// pin latch register fields
`define MIL_PL_SYNC_POL 7
`define MIL_PL_SYNC_EN 6
`define MIL_PL_PWR_FLAG 5
`define MIL_PL_PWR_EN 4
`define MIL_PL_PWR_EDGE 3
`define MIL_PL_NMI_FLAG 2
`define MIL_PL_NMI_EN 1
`define MIL_PL_NMI_EDGE 0
// ===========================================================
// vector addresses and reset values
`define MIL_VEC_ADDR0 12'hFFC
`define MIL_VEC_ADDR1 12'hFF6
`define MIL_VEC_ADDR2 12'hFF4
`define MIL_VEC_ADDR3 12'hFF2
`define MIL_VEC_ADDR4 12'hFF0
`define MIL_RST_BYTE 8'h00
`endif

// ### include/mil_pkg.sv
// types of the interrupt option and pin latch logic
// assumes mil_defines.svh on the include path
package mil_pkg;
  // ===========================================================
  // peripheral requests, all active low
  typedef struct packed {
    logic timer3ReqN;
    logic portAReqN;
    logic portBReqN;
    logic timer2ReqN;
    logic serialBusReqN;
    logic timer1ReqN;
    logic ddcReqN;
    logic adcReqN;
  } mil_periph_req_t;
  // ===========================================================
  // core sequencer to block
  typedef struct packed {
    logic lastCycle;
    logic retInstr;
    logic [11:0] pc;
  } mil_core_in_t;
  // ===========================================================
  // block to core sequencer
  typedef struct packed {
    logic take;
    logic [2:0] vecNum;
    logic [11:0] vecAddr;
    logic pushPc;
    logic popPc;
    logic [1:0] flagSet;
  } mil_core_out_t;
  typedef enum logic [1:0] {
    MIL_MODE_NORMAL,
    MIL_MODE_IRQ,
    MIL_MODE_NMI
  } mil_mode_t;
endpackage

// ### rtl/mil_sync_edge.sv
// two-stage synchroniser with rising/falling edge pulse
// assumes pin comes from outside the clock domain
`timescale 1ns/1ps
module mil_sync_edge (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic pin,
  output logic level,
  output logic rise,
  output logic fall
);
  logic meta_q;
  logic sync_q;
  logic last_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= 1'b1;
      sync_q <= 1'b1;
      last_q <= 1'b1;
    end else begin
      meta_q <= pin;
      sync_q <= meta_q;
      last_q <= sync_q;
    end
  end
  assign level = sync_q;
  assign rise = sync_q & ~last_q;
  assign fall = ~sync_q & last_q;
endmodule // mil_sync_edge

// ### rtl/mil_edge_latch.sv
// one edge latch: set by a selected edge, cleared by a strobe
// assumes edge pulses already synchronous to clock
`timescale 1ns/1ps
module mil_edge_latch (
  input wire logic clock,
  input wire logic arst_n,
  input wire logic polRise,
  input wire logic rise,
  input wire logic fall,
  input wire logic clear,
  output logic latched
);
  logic latch_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      latch_q <= 1'b0;
    end else if (polRise ? rise : fall) begin
      latch_q <= 1'b1;
    end else if (clear) begin
      latch_q <= 1'b0;
    end
  end
  assign latched = latch_q;
endmodule // mil_edge_latch

// ### rtl/mil_irq_ctrl.sv
// interrupt option register, pin latch register and core entry/return sequencing
// assumes a byte-wide data-space port from the core; pins are asynchronous
`timescale 1ns/1ps
`include "mil_defines.svh"
// Function
// - option register write-only at C8h
// - vector one level when set, falling edge otherwise
// - vector two edge select, falling at zero
// - global enable masks all but non-maskable
// - pin latch register at EDh, byte access
// - nmi and power latches follow edge select
// - latch reaches vector only when enabled
// - flag reads latch, writing one clears
// - sync polarity bit picks sync edge
// - sync enable gates, write one clears, reads latch
// - polarity position reads live sync pin
// - edge and enable bits reset zero, write-only
// - entry swaps flags, pushes pc, loads vector
// - return restores flags and pops pc
// - vector zero falling edge, cleared by service
// - vector one ands timer3 and port requests
// - vector two ands sync, timer2, serial bus
// - vector two edge clears only on service
// - vector three ands timer1 and ddc, level
// - vector four ands power latch and converter
// - global disable keeps captured edges pending
// - timer request needs flag and mask set
// - fixed priority, maskable never preempts maskable
// - requests sampled only in last cycle
module mil_irq_ctrl
  import mil_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  output logic [7:0] rdData,
  output logic rdHit,
  input wire logic nonmaskablePin,
  input wire logic powerInPin,
  input wire logic syncPin,
  input wire mil_periph_req_t periphReq,
  input wire mil_core_in_t coreIn,
  output mil_core_out_t coreOut,
  output logic [1:0] returnFlagSet,
  output logic [11:0] savedPc
);
  // ===========================================================
  // register state
  logic vec1LevelSelect_q;
  logic vec2EdgeSelect_q;
  logic globalIrqEnable_q;
  logic syncPolarity_q;
  logic syncEnableFlag_q;
  logic powerInIrqEnable_q;
  logic powerInEdgeSelect_q;
  logic nonmaskableIrqEnable_q;
  logic nonmaskableEdgeSelect_q;
  logic wrOption;
  logic wrLatch;
  logic clrNmi;
  logic clrPwr;
  logic clrSync;
  // ===========================================================
  // decode
  assign wrOption = wrEn && (addr == `MIL_ADDR_OPTION);
  assign wrLatch = wrEn && (addr == `MIL_ADDR_LATCH);
  // a one written to a flag position is a clear strobe
  assign clrNmi = wrLatch && wrData[`MIL_PL_NMI_FLAG];
  assign clrPwr = wrLatch && wrData[`MIL_PL_PWR_FLAG];
  assign clrSync = wrLatch && wrData[`MIL_PL_SYNC_EN];

  // whole-byte write only; no read-modify-write exists on these addresses
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vec1LevelSelect_q <= 1'b0;
      vec2EdgeSelect_q <= 1'b0;
      globalIrqEnable_q <= 1'b0;
    end else if (wrOption) begin
      vec1LevelSelect_q <= wrData[`MIL_OPT_VEC1_LEVEL];
      vec2EdgeSelect_q <= wrData[`MIL_OPT_VEC2_EDGE];
      globalIrqEnable_q <= wrData[`MIL_OPT_GLOBAL_EN];
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      syncPolarity_q <= 1'b0;
      syncEnableFlag_q <= 1'b0;
      powerInIrqEnable_q <= 1'b0;
      powerInEdgeSelect_q <= 1'b0;
      nonmaskableIrqEnable_q <= 1'b0;
      nonmaskableEdgeSelect_q <= 1'b0;
    end else if (wrLatch) begin
      syncPolarity_q <= wrData[`MIL_PL_SYNC_POL];
      syncEnableFlag_q <= wrData[`MIL_PL_SYNC_EN];
      powerInIrqEnable_q <= wrData[`MIL_PL_PWR_EN];
      powerInEdgeSelect_q <= wrData[`MIL_PL_PWR_EDGE];
      nonmaskableIrqEnable_q <= wrData[`MIL_PL_NMI_EN];
      nonmaskableEdgeSelect_q <= wrData[`MIL_PL_NMI_EDGE];
    end
  end

  // ===========================================================
  // pin synchronisers and latches
  logic nmiRise;
  logic nmiFall;
  logic pwrRise;
  logic pwrFall;
  logic syncLevel, syncRise, syncFall;
  logic nonmaskableLatched;
  logic powerInLatched;
  logic syncLatched;

  mil_sync_edge u_nmiSync (.clock(clock), .arst_n(arst_n), .pin(nonmaskablePin),
    .level(), .rise(nmiRise), .fall(nmiFall));
  mil_sync_edge u_pwrSync (.clock(clock), .arst_n(arst_n), .pin(powerInPin),
    .level(), .rise(pwrRise), .fall(pwrFall));
  mil_sync_edge u_syncSync (.clock(clock), .arst_n(arst_n), .pin(syncPin),
    .level(syncLevel), .rise(syncRise), .fall(syncFall));

  // latches clear at reset so the flags start known
  mil_edge_latch u_nmiLatch (.clock(clock), .arst_n(arst_n), .polRise(nonmaskableEdgeSelect_q),
    .rise(nmiRise), .fall(nmiFall), .clear(clrNmi), .latched(nonmaskableLatched));
  mil_edge_latch u_pwrLatch (.clock(clock), .arst_n(arst_n), .polRise(powerInEdgeSelect_q),
    .rise(pwrRise), .fall(pwrFall), .clear(clrPwr), .latched(powerInLatched));
  mil_edge_latch u_syncLatch (.clock(clock), .arst_n(arst_n), .polRise(syncPolarity_q),
    .rise(syncRise), .fall(syncFall), .clear(clrSync), .latched(syncLatched));

  // ===========================================================
  // read path; option register address answers nothing
  // write-only edge and enable positions read as zero
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      rdData <= `MIL_RST_BYTE;
      rdHit <= 1'b0;
    end else begin
      rdHit <= rdEn && (addr == `MIL_ADDR_LATCH);
      rdData <= `MIL_RST_BYTE;
      if (rdEn && addr == `MIL_ADDR_LATCH) begin
        rdData[`MIL_PL_SYNC_POL] <= syncLevel;
        rdData[`MIL_PL_SYNC_EN] <= syncLatched;
        rdData[`MIL_PL_PWR_FLAG] <= powerInLatched;
        rdData[`MIL_PL_NMI_FLAG] <= nonmaskableLatched;
      end
    end
  end

  // ===========================================================
  // vector request lines, active low where combined
  logic vec0Line;
  logic vec1Line;
  logic vec2Line;
  logic vec2SelLast_q;
  logic vec2Sel;
  logic vec1LineLast_q;
  logic vec3Line;
  logic vec4Line;
  logic vec2EdgeSeen;
  logic vec1EdgeSeen;

  // latch outputs are gated by their enables before combining
  assign vec0Line = ~(nonmaskableLatched & nonmaskableIrqEnable_q);
  assign vec1Line = periphReq.timer3ReqN & periphReq.portAReqN & periphReq.portBReqN;
  assign vec2Line = ~(syncLatched & syncEnableFlag_q) & periphReq.timer2ReqN
                    & periphReq.serialBusReqN;
  assign vec3Line = periphReq.timer1ReqN & periphReq.ddcReqN;
  assign vec4Line = ~(powerInLatched & powerInIrqEnable_q) & periphReq.adcReqN;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vec1LineLast_q <= 1'b1;
      vec2SelLast_q <= 1'b1;
    end else begin
      vec1LineLast_q <= vec1Line;
      vec2SelLast_q <= vec2Sel;
    end
  end

  assign vec1EdgeSeen = vec1LineLast_q & ~vec1Line;
  // select folded in ahead of the detector: flipping it to rising
  // while the line is high reads as an edge
  assign vec2Sel = vec2Line ^ vec2EdgeSelect_q;
  assign vec2EdgeSeen = vec2SelLast_q & ~vec2Sel;

  // ===========================================================
  // pending flip-flops; captured regardless of global enable
  logic vec0Pend_q;
  logic vec0LineLast_q;
  logic vec1Pend_q;
  logic vec2Pend_q;
  logic take0;
  logic take1;
  logic take2;
  logic take3;
  logic take4;
  logic vec1Req;
  logic vec3Req;
  logic vec4Req;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vec0LineLast_q <= 1'b1;
    end else begin
      vec0LineLast_q <= vec0Line;
    end
  end

  // set wins over the service clear
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vec0Pend_q <= 1'b0;
    end else if (vec0LineLast_q && !vec0Line) begin
      vec0Pend_q <= 1'b1;
    end else if (take0) begin
      vec0Pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vec1Pend_q <= 1'b0;
    end else if (vec1EdgeSeen) begin
      vec1Pend_q <= 1'b1;
    end else if (take1) begin
      vec1Pend_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      vec2Pend_q <= 1'b0;
    end else if (vec2EdgeSeen) begin
      vec2Pend_q <= 1'b1;
    end else if (take2) begin
      vec2Pend_q <= 1'b0;
    end
  end

  // vector one edges are captured in level mode too
  assign vec1Req = vec1LevelSelect_q ? ~vec1Line : vec1Pend_q;
  assign vec3Req = ~vec3Line;
  assign vec4Req = ~vec4Line;

  // ===========================================================
  // mode tracking and priority arbitration
  mil_mode_t mode_q;
  mil_mode_t prevMode_q;
  logic maskOpen;
  logic [11:0] savedPc_q;

  // no nesting of maskable routines; nmi also masks them
  assign maskOpen = globalIrqEnable_q && (mode_q == MIL_MODE_NORMAL);
  assign take0 = coreIn.lastCycle && vec0Pend_q && (mode_q != MIL_MODE_NMI);
  assign take1 = coreIn.lastCycle && !take0 && maskOpen && vec1Req;
  assign take2 = coreIn.lastCycle && !take0 && maskOpen && !vec1Req && vec2Pend_q;
  assign take3 = coreIn.lastCycle && !take0 && maskOpen && !vec1Req && !vec2Pend_q && vec3Req;
  assign take4 = coreIn.lastCycle && !take0 && maskOpen && !vec1Req && !vec2Pend_q
                 && !vec3Req && vec4Req;

  logic takeAny;
  logic doReturn;
  assign takeAny = take0 | take1 | take2 | take3 | take4;
  // an nmi entry on a return's last cycle wins; that return is not acted on
  assign doReturn = coreIn.retInstr && coreIn.lastCycle && !takeAny;

  // a return from nmi goes back to an interrupted maskable routine
  // reset lands in nmi mode until the first return
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= MIL_MODE_NMI;
      prevMode_q <= MIL_MODE_NORMAL;
    end else if (take0) begin
      prevMode_q <= mode_q;
      mode_q <= MIL_MODE_NMI;
    end else if (takeAny) begin
      prevMode_q <= mode_q;
      mode_q <= MIL_MODE_IRQ;
    end else if (doReturn) begin
      mode_q <= (mode_q == MIL_MODE_NMI && prevMode_q == MIL_MODE_IRQ) ? MIL_MODE_IRQ
                                                                         : MIL_MODE_NORMAL;
      prevMode_q <= MIL_MODE_NORMAL;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      savedPc_q <= 12'h000;
    end else if (takeAny) begin
      savedPc_q <= coreIn.pc;
    end
  end

  // ===========================================================
  // answer to the core sequencer, one cycle after the sample
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      coreOut <= '0;
      returnFlagSet <= 2'h0;
    end else begin
      coreOut.take <= takeAny;
      coreOut.pushPc <= takeAny;
      coreOut.popPc <= doReturn;
      returnFlagSet <= 2'(prevMode_q);
      if (take0) begin
        coreOut.vecNum <= 3'h0;
        coreOut.vecAddr <= `MIL_VEC_ADDR0;
        coreOut.flagSet <= 2'(MIL_MODE_NMI);
      end else if (take1) begin
        coreOut.vecNum <= 3'h1;
        coreOut.vecAddr <= `MIL_VEC_ADDR1;
        coreOut.flagSet <= 2'(MIL_MODE_IRQ);
      end else if (take2) begin
        coreOut.vecNum <= 3'h2;
        coreOut.vecAddr <= `MIL_VEC_ADDR2;
        coreOut.flagSet <= 2'(MIL_MODE_IRQ);
      end else if (take3) begin
        coreOut.vecNum <= 3'h3;
        coreOut.vecAddr <= `MIL_VEC_ADDR3;
        coreOut.flagSet <= 2'(MIL_MODE_IRQ);
      end else if (take4) begin
        coreOut.vecNum <= 3'h4;
        coreOut.vecAddr <= `MIL_VEC_ADDR4;
        coreOut.flagSet <= 2'(MIL_MODE_IRQ);
      end else if (doReturn) begin
        coreOut.flagSet <= (mode_q == MIL_MODE_NMI && prevMode_q == MIL_MODE_IRQ)
                           ? 2'(MIL_MODE_IRQ) : 2'(MIL_MODE_NORMAL);
      end
    end
  end

  assign savedPc = savedPc_q;

  // timer requests arrive already gated by flag and mask
endmodule // mil_irq_ctrl

// ### dv/mil_irq_ctrl_asserts.sv
// port checker for the interrupt option and pin latch logic
// assumes binding into every mil_irq_ctrl instance
`timescale 1ns/1ps
module mil_irq_ctrl_asserts
  import mil_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrEn,
  input wire logic rdEn,
  input wire logic [7:0] rdData,
  input wire logic rdHit,
  input wire logic nonmaskablePin,
  input wire logic powerInPin,
  input wire logic syncPin,
  input wire mil_periph_req_t periphReq,
  input wire mil_core_in_t coreIn,
  input wire mil_core_out_t coreOut,
  input wire logic [1:0] returnFlagSet,
  input wire logic [11:0] savedPc
);
  // ===========================================================
  // shadow of the global enable
  logic gen_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) gen_q <= 1'b0;
    else if (wrEn && addr == 8'hC8) gen_q <= wrData[4];
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ===========================================================
  // properties
  a_take_last_cycle: assert property (coreOut.take |-> $past(coreIn.lastCycle))
    else $error("take without last cycle");
  a_take_push_pc: assert property (coreOut.take |-> coreOut.pushPc)
    else $error("take without push");
  a_take_saved_pc: assert property (coreOut.take |-> savedPc == $past(coreIn.pc))
    else $error("saved pc wrong");
  a_vec_addr_map: assert property (coreOut.take |->
    (coreOut.vecNum == 3'h0 && coreOut.vecAddr == 12'hFFC) || (coreOut.vecNum == 3'h1 && coreOut.vecAddr == 12'hFF6)
    || (coreOut.vecNum == 3'h2 && coreOut.vecAddr == 12'hFF4) || (coreOut.vecNum == 3'h3 && coreOut.vecAddr == 12'hFF2)
    || (coreOut.vecNum == 3'h4 && coreOut.vecAddr == 12'hFF0))
    else $error("vector address wrong");
  a_mask_global_en: assert property (coreOut.take && coreOut.vecNum != 3'h0 |-> $past(gen_q))
    else $error("maskable taken while disabled");
  a_latch_read_hit: assert property (rdEn && addr == 8'hED |=> rdHit && rdData[4:3] == 2'h0 && rdData[1:0] == 2'h0)
    else $error("latch read wrong");
  a_option_read_none: assert property (rdEn && addr != 8'hED |=> !rdHit && rdData == 8'h00)
    else $error("option read returned data");
  a_return_pops: assert property (coreIn.lastCycle && coreIn.retInstr |=> coreOut.popPc)
    else $error("return without pop");
  a_return_flags: assert property (coreOut.popPc |-> coreOut.flagSet == $past(returnFlagSet))
    else $error("flags not restored");
endmodule // mil_irq_ctrl_asserts

bind mil_irq_ctrl mil_irq_ctrl_asserts u_chk (.clock(clock), .arst_n(arst_n), .addr(addr), .wrData(wrData),
  .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData), .rdHit(rdHit), .nonmaskablePin(nonmaskablePin),
  .powerInPin(powerInPin), .syncPin(syncPin), .periphReq(periphReq), .coreIn(coreIn), .coreOut(coreOut),
  .returnFlagSet(returnFlagSet), .savedPc(savedPc));

// ### dv/mil_core_model.sv
// core sequencer model: instruction ends, returns, one-level pc stack
// assumes the testbench asks for returns through retReq
`timescale 1ns/1ps
module mil_core_model
  import mil_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic retReq,
  input wire mil_core_out_t coreOut,
  output mil_core_in_t coreIn,
  output int takeCnt,
  output int popCnt,
  output logic [2:0] lastVec
);
  logic [1:0] phase_q;
  logic [11:0] pc_q;
  logic [11:0] stack_q;
  // every fourth cycle ends an instruction
  assign coreIn.lastCycle = (phase_q == 2'h3);
  assign coreIn.retInstr = retReq && coreIn.lastCycle;
  assign coreIn.pc = pc_q;
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      phase_q <= 2'h0;
      pc_q <= 12'h000;
      stack_q <= 12'h000;
    end else begin
      phase_q <= phase_q + 2'h1;
      if (coreOut.take) begin
        stack_q <= pc_q;
        pc_q <= coreOut.vecAddr;
      end else if (coreOut.popPc) begin
        pc_q <= stack_q;
      end else if (coreIn.lastCycle) begin
        pc_q <= pc_q + 12'h001;
      end
    end
  end
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      takeCnt <= 0;
      popCnt <= 0;
      lastVec <= 3'h0;
    end else begin
      if (coreOut.take) takeCnt <= takeCnt + 1;
      if (coreOut.take) lastVec <= coreOut.vecNum;
      if (coreOut.popPc) popCnt <= popCnt + 1;
    end
  end
endmodule // mil_core_model

// ### dv/testbench.sv
// self-checking bench for mil_irq_ctrl with a core model
// assumes the checker binds itself to the design
`timescale 1ns/1ps
module testbench;
  import mil_pkg::*;
  logic clock = 1'b0;
  logic arst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrEn = 1'b0;
  logic rdEn = 1'b0;
  logic nmiPin = 1'b1;
  logic pwrPin = 1'b1;
  logic syncPin = 1'b1;
  logic retReq = 1'b0;
  mil_periph_req_t periphReq = 8'hFF;
  logic [7:0] rdData;
  logic rdHit;
  mil_core_in_t coreIn;
  mil_core_out_t coreOut;
  logic [1:0] returnFlagSet;
  logic [11:0] savedPc;
  int takeCnt;
  int popCnt;
  logic [2:0] lastVec;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clock = ~clock;
  mil_irq_ctrl dut (.clock(clock), .arst_n(arst_n), .addr(addr), .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn),
    .rdData(rdData), .rdHit(rdHit), .nonmaskablePin(nmiPin), .powerInPin(pwrPin), .syncPin(syncPin),
    .periphReq(periphReq), .coreIn(coreIn), .coreOut(coreOut), .returnFlagSet(returnFlagSet), .savedPc(savedPc));
  mil_core_model u_core (.clock(clock), .arst_n(arst_n), .retReq(retReq), .coreOut(coreOut), .coreIn(coreIn),
    .takeCnt(takeCnt), .popCnt(popCnt), .lastVec(lastVec));
  // ===========================================================
  // helpers
  task end_sim;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count++;
      end_sim();
    end
  end
  task chk(string what, logic [15:0] seen, logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    wrEn <= 1'b1;
    addr <= a;
    wrData <= d;
    @(posedge clock);
    wrEn <= 1'b0;
  endtask
  task rdChk(logic [7:0] a, logic [7:0] exp);
    @(posedge clock);
    rdEn <= 1'b1;
    addr <= a;
    @(posedge clock);
    rdEn <= 1'b0;
    #1;
    chk("rdData", {8'h00, rdData}, {8'h00, exp});
    chk("rdHit", {15'h0, rdHit}, {15'h0, a == 8'hED});
    @(posedge clock);
  endtask
  task idle(int n);
    repeat (n) @(posedge clock);
  endtask
  task waitTake(int n);
    for (int i = 0; i < 200 && takeCnt != n; i++) begin
      @(posedge clock);
      #1;
    end
    chk("takes", takeCnt[15:0], n[15:0]);
    @(posedge clock);
  endtask
  task retire;
    int p;
    p = popCnt;
    @(posedge clock);
    retReq <= 1'b1;
    for (int i = 0; i < 200 && popCnt == p; i++) begin
      @(posedge clock);
      #1;
    end
    @(posedge clock);
    retReq <= 1'b0;
    chk("pops", popCnt[15:0], p[15:0] + 16'h1);
  endtask
  // ===========================================================
  // scenarios
  task t_reset;
    rdChk(8'hED, 8'h80);
    rdChk(8'hC8, 8'h00);
    rdChk(8'h10, 8'h00);
    retire();
    chk("flags", {14'h0, coreOut.flagSet}, {14'h0, MIL_MODE_NORMAL});
    $display("done t_reset");
  endtask
  task t_nmi;
    wr(8'hED, 8'h02);
    nmiPin <= 1'b0;
    waitTake(1);
    chk("vec", {13'h0, lastVec}, 16'h0000);
    chk("vecAddr", {4'h0, coreOut.vecAddr}, 16'h0FFC);
    chk("flags", {14'h0, coreOut.flagSet}, {14'h0, MIL_MODE_NMI});
    rdChk(8'hED, 8'h84);
    wr(8'hED, 8'h06);
    rdChk(8'hED, 8'h80);
    nmiPin <= 1'b1;
    retire();
    $display("done t_nmi");
  endtask
  task t_prio;
    wr(8'hC8, 8'h40);
    periphReq.timer3ReqN <= 1'b0;
    periphReq.timer1ReqN <= 1'b0;
    idle(20);
    chk("takes", takeCnt[15:0], 16'h0001);
    wr(8'hC8, 8'h50);
    waitTake(2);
    chk("vec", {13'h0, lastVec}, 16'h0001);
    chk("vecAddr", {4'h0, coreOut.vecAddr}, 16'h0FF6);
    idle(20);
    chk("takes", takeCnt[15:0], 16'h0002);
    periphReq.timer3ReqN <= 1'b1;
    retire();
    waitTake(3);
    chk("vec", {13'h0, lastVec}, 16'h0003);
    periphReq.timer1ReqN <= 1'b1;
    retire();
    $display("done t_prio");
  endtask
  task t_sync;
    wr(8'hC8, 8'h00);
    wr(8'hED, 8'h40);
    syncPin <= 1'b0;
    idle(8);
    rdChk(8'hED, 8'h40);
    wr(8'hC8, 8'h10);
    waitTake(4);
    chk("vec", {13'h0, lastVec}, 16'h0002);
    wr(8'hED, 8'h40);
    rdChk(8'hED, 8'h00);
    syncPin <= 1'b1;
    retire();
    idle(20);
    chk("takes", takeCnt[15:0], 16'h0004);
    $display("done t_sync");
  endtask
  task t_pwr;
    wr(8'hED, 8'h10);
    pwrPin <= 1'b0;
    waitTake(5);
    chk("vec", {13'h0, lastVec}, 16'h0004);
    rdChk(8'hED, 8'hA0);
    wr(8'hED, 8'h30);
    rdChk(8'hED, 8'h80);
    pwrPin <= 1'b1;
    retire();
    idle(20);
    chk("takes", takeCnt[15:0], 16'h0005);
    $display("done t_pwr");
  endtask
  task t_edge;
    wr(8'hED, 8'h40);
    wr(8'hC8, 8'h30);
    waitTake(6);
    chk("vec", {13'h0, lastVec}, 16'h0002);
    retire();
    syncPin <= 1'b0;
    idle(8);
    chk("takes", takeCnt[15:0], 16'h0006);
    wr(8'hED, 8'h40);
    waitTake(7);
    chk("vec", {13'h0, lastVec}, 16'h0002);
    retire();
    syncPin <= 1'b1;
    wr(8'hC8, 8'h10);
    wr(8'hED, 8'h03);
    nmiPin <= 1'b0;
    idle(8);
    chk("takes", takeCnt[15:0], 16'h0007);
    nmiPin <= 1'b1;
    waitTake(8);
    chk("vec", {13'h0, lastVec}, 16'h0000);
    wr(8'hED, 8'h07);
    retire();
    idle(20);
    chk("takes", takeCnt[15:0], 16'h0008);
    $display("done t_edge");
  endtask
  initial begin
    repeat (8) @(posedge clock);
    arst_n <= 1'b1;
    t_reset();
    t_nmi();
    t_prio();
    t_sync();
    t_pwr();
    t_edge();
    end_sim();
  end
endmodule // testbench
